// >>> include/iic_defs.svh
/*
  Register offsets, field positions, reset values and timing figures of the two-wire bus
  controller. Assumes a 32-bit bus with one aligned word per register.
*/
`ifndef IIC_DEFS_SVH
`define IIC_DEFS_SVH

`define IIC_OFF_CTRL 8'h00
`define IIC_OFF_STAT 8'h04
`define IIC_OFF_TXQ 8'h08
`define IIC_OFF_RXD 8'h0c
`define IIC_OFF_ISR 8'h10
`define IIC_OFF_IER 8'h14
`define IIC_OFF_OWNADR 8'h18
`define IIC_OFF_GPO 8'h1c

`define IIC_CTRL_EN 0
`define IIC_CTRL_SRST 1
`define IIC_TXQ_START 8
`define IIC_TXQ_STOP 9
`define IIC_ISR_ARB 0
`define IIC_ISR_NACK 1
`define IIC_ISR_TXE 2
`define IIC_ISR_FREE 3
`define IIC_ISR_AAS 4
`define IIC_ISR_W 5

`define IIC_RST_OWNADR 10'h000
`define IIC_WIDE_PREFIX 5'h1e
`define IIC_QUEUE_DEPTH 16
`define IIC_STD_MAX_HZ 100000
`define IIC_FAST_MAX_HZ 400000
`define IIC_FAST_REJECT_NS 50

`endif

// >>> include/iic_pkg.sv
/*
  Types shared by the two-wire bus controller modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package iic_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_FREE, ST_START_A, ST_START_B, ST_BIT_LO, ST_BIT_HI,
    ST_ACK_LO, ST_ACK_HI, ST_THROTTLE, ST_RSTART, ST_STOP_A, ST_STOP_B
  } iic_state_t;
  typedef enum logic [1:0] {SPD_STANDARD, SPD_FAST, SPD_FAST_PLUS} iic_speed_t;
  typedef struct packed {
    logic stop;
    logic start;
    logic [7:0] data;
  } iic_entry_t;
endpackage : iic_pkg

// >>> include/iic_txq_if.sv
/*
  Transmit queue carrier between the controller core and its queue.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface iic_txq_if;
  logic push;
  iic_pkg::iic_entry_t wdata;
  logic pop;
  logic clr;
  logic full;
  logic empty;
  iic_pkg::iic_entry_t rdata;
  modport user (output push, wdata, pop, clr, input full, empty, rdata);
  modport store (input push, wdata, pop, clr, output full, empty, rdata);
endinterface : iic_txq_if
`default_nettype wire

// >>> hdl/iic_glitch_filter.sv
/*
  Three-stage synchroniser followed by a stable-count glitch filter for one bus line.
  Assumes an asynchronous input and a DELAY of 0 to 255 system clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module iic_glitch_filter #(
  parameter int unsigned DELAY = 0
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic line_i,
  output logic line_o
);
  localparam logic [7:0] DLY = 8'(DELAY);
  typedef struct packed {
    logic [2:0] sync;
    logic [7:0] cnt;
    logic out;
  } iic_filt_st_t;
  localparam iic_filt_st_t RST = '{sync: 3'h7, cnt: 8'h00, out: 1'b1};
  iic_filt_st_t q, d;

  always_comb begin
    d = q;
    d.sync = {q.sync[1:0], line_i};
    if (q.sync[1] != q.sync[2] || q.sync[2] == q.out) begin
      d.cnt = 8'h00;
    end else if (DLY == 8'h00) begin
      d.out = q.sync[2];
    end else if (q.cnt + 8'h01 >= DLY) begin
      d.out = q.sync[2];
      d.cnt = 8'h00;
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      q <= RST;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign line_o = q.out;
endmodule : iic_glitch_filter
`default_nettype wire

// >>> hdl/iic_tx_queue.sv
/*
  Transmit queue holding data bytes with their start and stop flags.
  Assumes push is ignored when full and pop is ignored when empty; head is shown ahead.
*/
`timescale 1ns/1ps
`default_nettype none
module iic_tx_queue #(
  parameter int unsigned DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  iic_txq_if.store txq
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    iic_pkg::iic_entry_t [DEPTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } iic_q_st_t;
  iic_q_st_t q, d;
  logic do_push, do_pop;

  always_comb begin
    d = q;
    do_push = txq.push && !txq.full;
    do_pop = txq.pop && !txq.empty;
    if (do_push) begin
      d.mem[q.wr] = txq.wdata;
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (do_pop) begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    if (txq.clr) begin
      d.rd = '0;
      d.wr = '0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign txq.full = (q.cnt == (AW + 1)'(DEPTH));
  assign txq.empty = (q.cnt == '0);
  assign txq.rdata = q.mem[q.rd];
endmodule : iic_tx_queue
`default_nettype wire

// >>> hdl/iic_bus_controller_core.sv
/*
  Two-wire bus controller core: APB registers, dynamic master sequencer, bus monitor,
  slave address detector and interrupt logic. Assumes external open-drain buffers and
  pull-ups on both lines, and a single clock with synchronous active-high reset.
*/
// Contract
// - arbitration is entered only if the bus was free when acquisition was attempted.
// - after its own start the controller releases the bus when another master wins a bit.
// - a request made while the bus is busy waits until the bus is next free.
// - the dynamic path acts only as master with 7-bit addresses.
// - queue entries carrying no start flag while idle leave the dynamic path inactive.
// - start and stop flags sit with the data in the queue and act when the entry is popped.
// - each line filter has a build-time width of 0 to 255 system clock cycles.
// - a filter width of zero still waits for two matching synchronised samples, so one-cycle glitches are dropped.
// - the filters can give at least 50 ns of rejection and may give more.
// - the serial clock is exact only when the system clock is an integer multiple of it.
// - each line is presented as separate input, output and output enable signals.
// - a software soft reset returns all registers to their initial values.
// - while throttling as master transmitter the data line is driven to a build-time level.
// - a build-time option selects 10-bit or 7-bit slave address matching.
// - phase timing uses a half-period low phase at standard rate and a three-fifths low phase at fast and fast-plus rates.
`timescale 1ns/1ps
`default_nettype none
`include "iic_defs.svh"
module iic_bus_controller_core #(
  parameter int unsigned system_clock_hz = 100_000_000,
  parameter int unsigned target_serial_clock_hz = 100_000,
  parameter bit wide_address_enable = 1'b0,
  parameter int unsigned general_output_width = 1,
  parameter int unsigned scl_filter_cycles = 0,
  parameter int unsigned sda_filter_cycles = 0,
  parameter bit sda_throttle_level = 1'b1,
  parameter int unsigned queue_depth = `IIC_QUEUE_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o,
  output logic [general_output_width-1:0] gpo_o
);
  function automatic iic_pkg::iic_speed_t speed_of(input int unsigned hz);
    if (hz <= `IIC_STD_MAX_HZ) begin
      return iic_pkg::SPD_STANDARD;
    end else if (hz <= `IIC_FAST_MAX_HZ) begin
      return iic_pkg::SPD_FAST;
    end
    return iic_pkg::SPD_FAST_PLUS;
  endfunction : speed_of

  // integer division: exact only for whole ratios
  function automatic logic [15:0] phase_cycles(input bit high);
    int unsigned period;
    int unsigned low;
    period = system_clock_hz / target_serial_clock_hz;
    if (speed_of(target_serial_clock_hz) == iic_pkg::SPD_STANDARD) begin
      low = period / 2;
    end else begin
      low = (period * 3) / 5;
    end
    return high ? 16'(period - low) : 16'(low);
  endfunction : phase_cycles

  localparam iic_pkg::iic_speed_t SPEED = speed_of(target_serial_clock_hz);
  localparam logic [15:0] T_LOW = phase_cycles(1'b0);
  localparam logic [15:0] T_HIGH = phase_cycles(1'b1);
  localparam int unsigned FAST_REJECT_CYC =
    (`IIC_FAST_REJECT_NS * (system_clock_hz / 1000) + 999_999) / 1_000_000;
  localparam bit FAST_OK = (scl_filter_cycles >= FAST_REJECT_CYC) &&
    (sda_filter_cycles >= FAST_REJECT_CYC);

  typedef struct packed {
    iic_pkg::iic_state_t state;
    logic [15:0] cnt;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic rd;
    logic adr;
    logic last;
    logic own;
    logic scl_oe;
    logic sda_oe;
    logic sda_o;
    logic busy;
    logic scl_p;
    logic sda_p;
    logic en;
    logic flush;
    logic [`IIC_ISR_W-1:0] isr;
    logic [`IIC_ISR_W-1:0] ier;
    logic [7:0] gpo;
    logic [9:0] own_adr;
    logic [7:0] rx;
    logic rxv;
    logic mon_act;
    logic mon_second;
    logic [3:0] mon_n;
    logic [7:0] mon_sh;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } iic_core_st_t;

  iic_core_st_t q, d;
  iic_txq_if txq ();
  logic scl_f, sda_f;
  logic setup, access, start_ev, stop_ev, rise, rcv;
  logic [7:0] nsh;
  iic_pkg::iic_entry_t e;

  iic_glitch_filter #(.DELAY(scl_filter_cycles)) u_scl_filt (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .line_i(scl_i),
    .line_o(scl_f)
  );

  iic_glitch_filter #(.DELAY(sda_filter_cycles)) u_sda_filt (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .line_i(sda_i),
    .line_o(sda_f)
  );

  iic_tx_queue #(.DEPTH(queue_depth)) u_txq (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .txq(txq.store)
  );

  always_comb begin
    d = q;
    e = txq.rdata;
    nsh = {q.mon_sh[6:0], sda_f};
    setup = psel_i && !penable_i;
    access = psel_i && penable_i && q.pready;
    rcv = q.rd && !q.adr;
    txq.push = 1'b0;
    txq.pop = 1'b0;
    txq.wdata = pwdata_i[9:0];
    txq.clr = q.flush;
    d.flush = 1'b0;
    // apb slave: answer one cycle after setup
    d.pready = setup;
    if (setup) begin
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
      case (paddr_i)
        `IIC_OFF_CTRL: d.prdata[`IIC_CTRL_EN] = q.en;
        `IIC_OFF_STAT: d.prdata[7:0] = {FAST_OK, SPEED, q.own, q.busy, q.rxv,
                                        txq.full, txq.empty};
        `IIC_OFF_TXQ: d.pslverr = pwrite_i && txq.full;
        `IIC_OFF_RXD: d.prdata[7:0] = q.rx;
        `IIC_OFF_ISR: d.prdata[`IIC_ISR_W-1:0] = q.isr;
        `IIC_OFF_IER: d.prdata[`IIC_ISR_W-1:0] = q.ier;
        `IIC_OFF_OWNADR: d.prdata[9:0] = q.own_adr;
        `IIC_OFF_GPO: d.prdata[7:0] = q.gpo;
        default: d.pslverr = 1'b1;
      endcase
    end
    if (access && pwrite_i) begin
      case (paddr_i)
        `IIC_OFF_CTRL: d.en = pwdata_i[`IIC_CTRL_EN];
        `IIC_OFF_TXQ: txq.push = 1'b1;
        `IIC_OFF_ISR: d.isr = q.isr & ~pwdata_i[`IIC_ISR_W-1:0];
        `IIC_OFF_IER: d.ier = pwdata_i[`IIC_ISR_W-1:0];
        `IIC_OFF_OWNADR: d.own_adr = pwdata_i[9:0];
        `IIC_OFF_GPO: d.gpo = pwdata_i[7:0];
        default: d.en = q.en;
      endcase
    end
    if (access && !pwrite_i && paddr_i == `IIC_OFF_RXD) begin
      d.rxv = 1'b0;
    end
    // bus monitor
    d.scl_p = scl_f;
    d.sda_p = sda_f;
    start_ev = scl_f && q.scl_p && q.sda_p && !sda_f;
    stop_ev = scl_f && q.scl_p && !q.sda_p && sda_f;
    rise = scl_f && !q.scl_p;
    if (start_ev) begin
      d.busy = 1'b1;
    end else if (stop_ev) begin
      d.busy = 1'b0;
      d.isr[`IIC_ISR_FREE] = 1'b1;
    end
    // slave address detector
    if (start_ev) begin
      d.mon_act = 1'b1;
      d.mon_second = 1'b0;
      d.mon_n = 4'h0;
    end else if (rise && q.mon_act && !q.own) begin
      if (q.mon_n == 4'h8) begin
        d.mon_n = 4'h0;
      end else begin
        d.mon_sh = nsh;
        d.mon_n = q.mon_n + 4'h1;
        if (q.mon_n == 4'h7) begin
          d.mon_act = 1'b0;
          if (q.mon_second) begin
            d.isr[`IIC_ISR_AAS] = d.isr[`IIC_ISR_AAS] | (nsh == q.own_adr[7:0]);
          end else if (wide_address_enable && nsh[7:3] == `IIC_WIDE_PREFIX) begin
            d.mon_act = (nsh[2:1] == q.own_adr[9:8]);
            d.mon_second = 1'b1;
          end else if (!wide_address_enable && nsh[7:1] == q.own_adr[6:0]) begin
            d.isr[`IIC_ISR_AAS] = 1'b1;
          end
        end
      end
    end
    // dynamic master sequencer, 7-bit addressing only
    if (q.cnt != 16'h0000) begin
      d.cnt = q.cnt - 16'h0001;
    end
    d.sda_o = 1'b0;
    case (q.state)
      iic_pkg::ST_IDLE: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        if (q.en && !txq.empty) begin
          txq.pop = 1'b1;
          if (e.start) begin
            d.shreg = e.data;
            d.rd = e.data[0];
            d.adr = 1'b1;
            d.last = e.stop;
            d.cnt = T_HIGH;
            d.state = q.busy ? iic_pkg::ST_WAIT_FREE : iic_pkg::ST_START_A;
          end
        end
      end
      iic_pkg::ST_WAIT_FREE: begin
        if (!q.busy) begin
          d.cnt = T_HIGH;
          d.state = iic_pkg::ST_START_A;
        end
      end
      iic_pkg::ST_RSTART: begin
        d.scl_oe = 1'b1;
        d.sda_oe = 1'b0;
        if (q.cnt == 16'h0000) begin
          d.cnt = T_HIGH;
          d.state = iic_pkg::ST_START_A;
        end
      end
      iic_pkg::ST_START_A: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        if (q.busy && !q.own) begin
          d.state = iic_pkg::ST_WAIT_FREE;
        end else if (!scl_f) begin
          d.cnt = T_HIGH;
        end else if (q.cnt == 16'h0000) begin
          d.sda_oe = 1'b1;
          d.cnt = T_HIGH;
          d.state = iic_pkg::ST_START_B;
        end
      end
      iic_pkg::ST_START_B: begin
        if (q.cnt == 16'h0000) begin
          d.scl_oe = 1'b1;
          d.own = 1'b1;
          d.bitn = 3'h7;
          d.cnt = T_LOW;
          d.state = iic_pkg::ST_BIT_LO;
        end
      end
      iic_pkg::ST_BIT_LO: begin
        d.sda_oe = !q.shreg[7];
        if (q.cnt == 16'h0000) begin
          d.scl_oe = 1'b0;
          d.cnt = T_HIGH;
          d.state = iic_pkg::ST_BIT_HI;
        end
      end
      iic_pkg::ST_BIT_HI: begin
        if (!scl_f) begin
          d.cnt = T_HIGH;
        end else if (q.cnt == 16'h0000) begin
          if (!rcv && !q.sda_oe && !sda_f) begin
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            d.own = 1'b0;
            d.isr[`IIC_ISR_ARB] = 1'b1;
            d.state = iic_pkg::ST_IDLE;
          end else begin
            d.shreg = {q.shreg[6:0], sda_f};
            d.scl_oe = 1'b1;
            d.cnt = T_LOW;
            d.bitn = q.bitn - 3'h1;
            d.state = (q.bitn == 3'h0) ? iic_pkg::ST_ACK_LO : iic_pkg::ST_BIT_LO;
          end
        end
      end
      iic_pkg::ST_ACK_LO: begin
        d.sda_oe = rcv && !q.last;
        if (q.cnt == 16'h0000) begin
          d.scl_oe = 1'b0;
          d.cnt = T_HIGH;
          d.state = iic_pkg::ST_ACK_HI;
        end
      end
      iic_pkg::ST_ACK_HI: begin
        if (!scl_f) begin
          d.cnt = T_HIGH;
        end else if (q.cnt == 16'h0000) begin
          d.scl_oe = 1'b1;
          d.cnt = T_LOW;
          if (!rcv && sda_f) begin
            d.isr[`IIC_ISR_NACK] = 1'b1;
            d.state = iic_pkg::ST_STOP_A;
          end else begin
            if (rcv) begin
              d.rx = q.shreg;
              d.rxv = 1'b1;
            end
            d.state = q.last ? iic_pkg::ST_STOP_A : iic_pkg::ST_THROTTLE;
          end
        end
      end
      iic_pkg::ST_THROTTLE: begin
        d.scl_oe = 1'b1;
        d.sda_oe = !q.rd;
        d.sda_o = !q.rd && sda_throttle_level;
        if (txq.empty && !q.rd) begin
          d.isr[`IIC_ISR_TXE] = 1'b1;
        end
        if (!txq.empty && !(q.rd && q.rxv)) begin
          txq.pop = 1'b1;
          d.last = e.stop;
          d.cnt = T_LOW;
          if (e.start) begin
            d.shreg = e.data;
            d.rd = e.data[0];
            d.adr = 1'b1;
            d.state = iic_pkg::ST_RSTART;
          end else begin
            d.adr = 1'b0;
            d.shreg = q.rd ? 8'hff : e.data;
            d.bitn = 3'h7;
            d.state = iic_pkg::ST_BIT_LO;
          end
        end
      end
      iic_pkg::ST_STOP_A: begin
        d.sda_oe = 1'b1;
        if (q.cnt == 16'h0000) begin
          d.scl_oe = 1'b0;
          d.cnt = T_HIGH;
          d.state = iic_pkg::ST_STOP_B;
        end
      end
      iic_pkg::ST_STOP_B: begin
        if (!scl_f) begin
          d.cnt = T_HIGH;
        end else if (q.cnt == 16'h0000) begin
          d.sda_oe = 1'b0;
          d.own = 1'b0;
          d.state = iic_pkg::ST_IDLE;
        end
      end
      default: d.state = iic_pkg::ST_IDLE;
    endcase
    d.irq = |(q.isr & q.ier);
    if (access && pwrite_i && paddr_i == `IIC_OFF_CTRL && pwdata_i[`IIC_CTRL_SRST]) begin
      d = '0;
      d.own_adr = `IIC_RST_OWNADR;
      d.scl_p = scl_f;
      d.sda_p = sda_f;
      d.flush = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign scl_o = 1'b0;
  assign scl_oe_o = q.scl_oe;
  assign sda_o = q.sda_o;
  assign sda_oe_o = q.sda_oe;
  assign irq_o = q.irq;
  assign gpo_o = q.gpo[general_output_width-1:0];
endmodule : iic_bus_controller_core
`default_nettype wire

// >>> verification/iic_bus_props.sv
/*
  Assertions on the top ports of the two-wire bus controller core.
  Assumes one clock, a synchronous active-high reset and clk_en_i held high.
*/
`timescale 1ns/1ps
`default_nettype none
module iic_bus_props #(
  parameter int unsigned system_clock_hz = 100_000_000,
  parameter int unsigned target_serial_clock_hz = 100_000,
  parameter int unsigned general_output_width = 1,
  parameter int unsigned scl_filter_cycles = 0,
  parameter int unsigned sda_filter_cycles = 0
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic irq_o,
  input wire logic [general_output_width-1:0] gpo_o
);
  localparam logic [1:0] SPD = (target_serial_clock_hz <= 100000) ? 2'h0 :
    (target_serial_clock_hz <= 400000) ? 2'h1 : 2'h2;
  localparam logic FLT = (64'(scl_filter_cycles) * 64'd1000000000 >= 64'd50 * system_clock_hz)
    && (64'(sda_filter_cycles) * 64'd1000000000 >= 64'd50 * system_clock_hz);
  logic acc;
  logic setup;
  logic foreign_q;
  assign acc = psel_i && penable_i && pready_o;
  assign setup = psel_i && !penable_i;
  // frame started by another master while this one is silent
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) foreign_q <= 1'b0;
    else if ($fell(sda_i) && scl_i && !sda_oe_o && !scl_oe_o) foreign_q <= 1'b1;
    else if ($rose(sda_i) && scl_i) foreign_q <= 1'b0;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  scl_drive_low_a: assert property (scl_oe_o |-> !scl_o)
    else $error("clock line driven high");
  foreign_hold_a: assert property (foreign_q |-> !scl_oe_o && !sda_oe_o)
    else $error("bus taken while another master owns it");
  throttle_level_a: assert property (sda_o |-> sda_oe_o && scl_oe_o)
    else $error("data level driven outside throttling");
  pready_timing_a: assert property (setup |=> pready_o)
    else $error("no answer after setup");
  pready_cause_a: assert property (pready_o |-> $past(setup))
    else $error("answer without setup");
  speed_field_a: assert property (acc && !pwrite_i && paddr_i == 8'h04 |->
    prdata_o[7:5] == {FLT, SPD})
    else $error("speed or filter field wrong");
  unmapped_err_a: assert property (acc && paddr_i > 8'h1c |-> pslverr_o)
    else $error("unmapped access not refused");
  soft_reset_a: assert property (acc && pwrite_i && paddr_i == 8'h00 && pwdata_i[1] |->
    ##2 gpo_o == '0 ##1 !irq_o)
    else $error("soft reset left state");
  mask_irq_a: assert property (acc && pwrite_i && paddr_i == 8'h14 && pwdata_i[5:0] == 6'h00
    |-> ##2 !irq_o)
    else $error("masked interrupt still high");
  cover property (foreign_q ##1 !foreign_q);
  cover property (sda_o && sda_oe_o);
  cover property (acc && pslverr_o);
endmodule : iic_bus_props
bind iic_bus_controller_core iic_bus_props #(.system_clock_hz(system_clock_hz),
  .target_serial_clock_hz(target_serial_clock_hz), .general_output_width(general_output_width),
  .scl_filter_cycles(scl_filter_cycles), .sda_filter_cycles(sda_filter_cycles)) props_i (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o),
  .gpo_o(gpo_o));
`default_nettype wire

// >>> verification/iic_far_end.sv
/*
  Far side of the two-wire bus: a slave that acks and logs bytes, and a second
  master that takes the bus on request. Assumes pulled-up wires resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module iic_far_end (
  input wire logic scl_w_i,
  input wire logic sda_w_i,
  input wire logic hog_i,
  output logic scl_pd_o,
  output logic sda_pd_o,
  output logic busy_o,
  output logic [7:0] first_o,
  output logic [7:0] last_o,
  output logic [7:0] nbytes_o
);
  logic [7:0] b;
  initial begin
    scl_pd_o = 1'b0;
    sda_pd_o = 1'b0;
    busy_o = 1'b0;
    first_o = 8'h00;
    last_o = 8'h00;
    nbytes_o = 8'h00;
    b = 8'h00;
    forever begin
      @(negedge sda_w_i iff (scl_w_i && !busy_o));
      fork : frame
        @(posedge sda_w_i iff scl_w_i);
        for (int k = 0; k < 64; k++) begin
          repeat (8) begin
            @(posedge scl_w_i);
            b = {b[6:0], sda_w_i};
          end
          if (k == 0) first_o = b;
          last_o = b;
          nbytes_o = nbytes_o + 8'h01;
          @(negedge scl_w_i);
          sda_pd_o = 1'b1;
          @(negedge scl_w_i);
          sda_pd_o = 1'b0;
        end
      join_any
      disable frame;
      sda_pd_o = 1'b0;
    end
  end
  // second master: start, nine clocks of 160 ns, stop
  always @(posedge hog_i) begin
    busy_o = 1'b1;
    #3 sda_pd_o = 1'b1;
    #80 scl_pd_o = 1'b1;
    sda_pd_o = 1'b0;
    repeat (9) begin
      #80 scl_pd_o = 1'b0;
      #80 scl_pd_o = 1'b1;
    end
    sda_pd_o = 1'b1;
    #80 scl_pd_o = 1'b0;
    #80 sda_pd_o = 1'b0;
    #80 busy_o = 1'b0;
  end
endmodule : iic_far_end
`default_nettype wire

// >>> verification/tb_top.sv
/*
  Self-checking bench of the two-wire bus controller core with an APB master.
  Assumes the far-side model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, hog = 0, hb;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, perr, scl_o, scl_oe, sda_o, sda_oe, irq, scl_pd, sda_pd, scl_w, sda_w;
  logic [0:0] gpo;
  logic [7:0] first, last, nb;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  always #5 clk = ~clk;
  assign scl_w = !(scl_oe && !scl_o) && !scl_pd;
  assign sda_w = (sda_oe ? sda_o : 1'b1) && !sda_pd;
  iic_bus_controller_core #(.target_serial_clock_hz(1_000_000), .scl_filter_cycles(5),
    .sda_filter_cycles(5)) uut (.ref_clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .irq_o(irq),
    .gpo_o(gpo));
  iic_far_end far (.scl_w_i(scl_w), .sda_w_i(sda_w), .hog_i(hog), .scl_pd_o(scl_pd),
    .sda_pd_o(sda_pd), .busy_o(hb), .first_o(first), .last_o(last), .nbytes_o(nb));
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, x, s);
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input string s);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0, r, e);
      n++;
    end while ((r & m) !== m && n < 3000);
    cmp(r & m, m, s);
  endtask : poll
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(8'h04, 32'hc1, "status after reset");
    rd(8'h10, 32'h0, "events after reset");
    rd(8'h18, 32'h0, "own address after reset");
    apb(1'b0, 8'h20, 32'h0, r, e);
    cmp(e, 1'b1, "unmapped read accepted");
    $display("reset test done");
  endtask : t_reset
  task automatic t_write();
    wr(8'h08, 32'h033);
    wr(8'h08, 32'h1a0);
    wr(8'h08, 32'h25a);
    wr(8'h14, 32'h8);
    wr(8'h00, 32'h1);
    poll(8'h10, 32'h8, "stop not seen");
    cmp(nb, 8'h02, "byte count");
    cmp(first, 8'ha0, "address byte");
    cmp(last, 8'h5a, "data byte");
    cmp(irq, 1'b1, "interrupt not raised");
    wr(8'h14, 32'h0);
    @(posedge clk);
    cmp(irq, 1'b0, "masked interrupt high");
    wr(8'h10, 32'h8);
    wr(8'h14, 32'h8);
    rd(8'h10, 32'h0, "event not cleared");
    cmp(irq, 1'b0, "cleared interrupt high");
    $display("write test done");
  endtask : t_write
  task automatic t_throttle();
    wr(8'h10, 32'h3f);
    wr(8'h08, 32'h1a0);
    poll(8'h10, 32'h4, "no throttle event");
    cmp({scl_oe, sda_oe, sda_o}, 3'b111, "throttle drive");
    wr(8'h08, 32'h2c3);
    poll(8'h10, 32'h8, "stop not seen");
    cmp(last, 8'hc3, "byte after throttle");
    $display("throttle test done");
  endtask : t_throttle
  task automatic t_busy();
    logic [7:0] n;
    logic bad;
    int k;
    wr(8'h10, 32'h3f);
    hog <= 1'b1;
    poll(8'h04, 32'h8, "bus not busy");
    wr(8'h08, 32'h3b4);
    n = nb;
    bad = 1'b0;
    k = 0;
    while (nb == n && k < 5000) begin
      @(posedge clk);
      k++;
      if (scl_oe && hb) bad = 1'b1;
    end
    cmp(bad, 1'b0, "joined a busy bus");
    cmp(first, 8'hb4, "deferred address");
    wr(8'h10, 32'h8);
    poll(8'h10, 32'h8, "no stop after deferred frame");
    hog <= 1'b0;
    $display("busy bus test done");
  endtask : t_busy
  task automatic t_srst();
    wr(8'h18, 32'h155);
    wr(8'h1c, 32'h1);
    cmp(gpo, 1'b1, "output not set");
    rd(8'h18, 32'h155, "own address");
    wr(8'h00, 32'h2);
    rd(8'h18, 32'h0, "own address kept");
    rd(8'h14, 32'h0, "mask kept");
    cmp(gpo, 1'b0, "output kept");
    $display("soft reset test done");
  endtask : t_srst
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_write();
    t_throttle();
    t_busy();
    t_srst();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
